// ---- core/gtsc_timing_signal_config.sv ----
// Purpose: Timing-pin polarity, lamp, sentence link and time-stamp stream logic.
// Assumes: One 100 MHz clock, synchronous active-low reset, clock enable.
// Notes:   Stream records are one-cycle strobes with no back-pressure.
// Behaviour
// - Bits 1 and 3 reserved, no function.
// - Bits 0,6,7 set trigger, rx, tx idle.
// - Conversion-ready output only when bit 2 set.
// - Bit 4 selects second-pulse idle level.
// - Bit 5 selects red lamp source.
// - Red lamp toggles on each second tick.
// - Yellow lamp toggles per handed-over buffer.
// - Digital inputs stored with each sample set.
// - Pulse edge plus sentences stamp samples on board.
// - Stamping done purely in dedicated logic.
// - Time and location inserted into data stream.
// - Power-on: pulse idle low, serial idle high.
// - Transmit output sends configuration sentences.
// - Sentence link runs at 4800 baud.
// - Leading edge only; pulses over 100 ns.
// - Idle-high pulse ticks on falling edge.
// - Conversion-ready rises at each conversion done.
`timescale 1ns/1ps
module gtsc_timing_signal_config
  import gtsc_pkg::*;
#(
  parameter int unsigned SAMPLE_W = 24,
  parameter int unsigned DIN_W    = 4,
  parameter logic [7:0]  BLOCK_ID = 8'h5a
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     clkEn,
  input  wire logic [gtsc_pkg::AW-1:0]  regAddr,
  input  wire logic [7:0]               regWrData,
  input  wire logic                     regWr,
  input  wire logic                     regRd,
  output logic      [7:0]               regRdData,
  input  wire logic                     secondPulsePin,
  input  wire logic                     triggerPin,
  input  wire logic                     serialRxPin,
  output logic                          serialTxPin,
  input  wire logic                     convDone,
  output logic                          convReadyPin,
  input  wire logic [DIN_W-1:0]         digitalInPin,
  input  wire logic                     sampleValid,
  input  wire logic [SAMPLE_W-1:0]      sampleData,
  input  wire logic                     bufferHandedOff,
  output logic                          redLamp,
  output logic                          yellowLamp,
  output logic                          triggerEvent,
  output logic                          streamValid,
  output logic      [1:0]               streamTag,
  output logic      [31:0]              streamData,
  output logic      [DIN_W-1:0]         streamDin
);
  import gtsc_pkg::*;

  // Configuration and control registers.
  logic [7:0]  cfg_q,      cfg_d;
  logic        lampProg_q, lampProg_d;
  logic        trigErr_q,  trigErr_d;

  // Synchronisers: stage one feeds stage two only.
  logic [2:0]       syncA_q, syncB_q;
  logic [DIN_W-1:0] dinA_q,  dinB_q;
  logic             secLvlPrev_q, trigLvlPrev_q;

  // Pulse, stamp and lamp state.
  logic        red_q, red_d, yel_q, yel_d;
  logic [31:0] secCnt_q, secCnt_d;
  logic [31:0] ticks_q, ticks_d;
  logic [7:0]  hiWidth_q, hiWidth_d;
  logic        secTick;
  logic        secLvl, trigLvl, rxLvl;
  logic        secLvlPrev, trigLvlPrev, secGlitch;
  logic [7:0]  rxCnt_q, rxCnt_d;
  logic [7:0]  rdData_q, rdData_d;

  // Transmit state.
  gtsc_txst_e  txSt_q, txSt_d;
  logic [15:0] txCnt_q, txCnt_d;
  logic [2:0]  txBit_q, txBit_d;
  logic [7:0]  txSh_q, txSh_d;
  logic        txPend_q, txPend_d;
  logic [7:0]  txBuf_q, txBuf_d;
  logic        txLine;

  // Output stream registers.
  logic             sv_q, sv_d;
  logic [1:0]       st_q, st_d;
  logic [31:0]      sd_q, sd_d;
  logic [DIN_W-1:0] sdin_q, sdin_d;
  logic             conv_q, conv_d;

  gtsc_uart_if rxIf ();

  gtsc_uart_rx #(.DIV(BAUD_DIV)) uRx (
    .clk    (clk),
    .rst_n  (rst_n),
    .clkEn  (clkEn),
    .rxLine (rxLvl),
    .up     (rxIf.rx)
  );

  // Two-stage synchronisers for every pin from outside the clock domain.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncA_q <= 3'b100; // Trigger and pulse idle low, receive idles high.
      syncB_q <= 3'b100;
      dinA_q  <= '0;
      dinB_q  <= '0;
    end else if (clkEn) begin
      syncA_q <= {serialRxPin, triggerPin, secondPulsePin};
      syncB_q <= syncA_q;
      dinA_q  <= digitalInPin;
      dinB_q  <= dinA_q;
    end
  end

  // Fold the idle level out so each line reads active-high (rx reads idle-high).
  assign secLvl  = syncB_q[0] ^ cfg_q[CFG_SEC_IDLE];
  assign trigLvl = syncB_q[1] ^ cfg_q[CFG_TRIG_IDLE];
  assign rxLvl   = syncB_q[2] ^ cfg_q[CFG_RX_IDLE];

  // The previous raw sample is folded with the present idle level, so a polarity write alone is never an edge.
  assign secLvlPrev  = secLvlPrev_q ^ cfg_q[CFG_SEC_IDLE];
  assign trigLvlPrev = trigLvlPrev_q ^ cfg_q[CFG_TRIG_IDLE];

  // Leading edge only marks a tick; width is irrelevant beyond the filter.
  assign secTick = secLvl && !secLvlPrev;

  // A trailing edge that follows a seen leading edge too soon is a glitch.
  assign secGlitch = !secLvl && secLvlPrev && hiWidth_q != 8'h00 && hiWidth_q < 8'(PULSE_MIN_CYC);

  // Raw synchronised levels of the previous cycle, reset to the power-on idle levels.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      secLvlPrev_q  <= 1'b0;
      trigLvlPrev_q <= 1'b0;
    end else if (clkEn) begin
      secLvlPrev_q  <= syncB_q[0];
      trigLvlPrev_q <= syncB_q[1];
    end
  end
  assign triggerEvent = trigLvl && !trigLvlPrev;

  // Register port, lamps, counters and the time-stamp stream.
  always_comb begin
    cfg_d      = cfg_q;
    lampProg_d = lampProg_q;
    trigErr_d  = trigErr_q;
    red_d      = red_q;
    yel_d      = yel_q;
    secCnt_d   = secCnt_q;
    ticks_d    = ticks_q + 32'h1;
    hiWidth_d  = 8'h00;
    rxCnt_d    = rxCnt_q;
    rdData_d   = 8'h00;
    txBuf_d    = txBuf_q;
    sv_d       = 1'b0;
    st_d       = st_q;
    sd_d       = sd_q;
    sdin_d     = sdin_q;
    conv_d     = convDone && cfg_q[CFG_CONV_EN];
    // A pulse shorter than the minimum width is recorded as a glitch flag, yet it still ticks.
    if (secGlitch) trigErr_d = 1'b1;
    // Width counts from a seen leading edge only, and saturates so a stuck pin never wraps.
    if (secTick) hiWidth_d = 8'h01;
    else if (secLvl && hiWidth_q != 8'h00 && hiWidth_q != 8'hff) hiWidth_d = hiWidth_q + 8'h1;
    else if (secLvl) hiWidth_d = hiWidth_q;
    if (secTick) begin
      secCnt_d = secCnt_q + 32'h1;
      ticks_d  = 32'h0;
      if (!cfg_q[CFG_LAMP_SRC]) red_d = !red_q;
    end
    if (cfg_q[CFG_LAMP_SRC]) red_d = lampProg_q;
    if (bufferHandedOff) yel_d = !yel_q;
    // Stream priority: sample, then second mark, then sentence byte.
    if (sampleValid) begin
      sv_d   = 1'b1;
      st_d   = TAG_SAMPLE;
      sd_d   = 32'(sampleData);
      sdin_d = dinB_q;
    end else if (secTick) begin
      sv_d   = 1'b1;
      st_d   = TAG_SECOND;
      sd_d   = secCnt_q + 32'h1;
      sdin_d = dinB_q;
    end else if (rxIf.byteValid) begin
      sv_d   = 1'b1;
      st_d   = TAG_SENTENCE;
      sd_d   = {ticks_q[23:0], rxIf.byteData};
      sdin_d = dinB_q;
    end
    if (rxIf.byteValid) rxCnt_d = rxCnt_q + 8'h1;
    if (regWr) begin
      case (regAddr)
        ADDR_CFG:     cfg_d = regWrData & CFG_USED_MASK;
        ADDR_LAMP:    lampProg_d = regWrData[0];
        ADDR_STATUS:  if (regWrData[0]) trigErr_d = 1'b0;
        ADDR_TX_DATA: txBuf_d = regWrData;
        default:      ;
      endcase
      // A glitch seen in the clearing cycle survives the clear.
      if (secGlitch) trigErr_d = 1'b1;
    end
    if (regRd) begin
      case (regAddr)
        ADDR_CFG:         rdData_d = cfg_q;
        ADDR_LAMP:        rdData_d = {6'h00, yel_q, red_q};
        ADDR_STATUS:      rdData_d = {5'h00, txPend_q || txSt_q != GTSC_TX_IDLE, secLvl, trigErr_q};
        ADDR_SEC_CNT:     rdData_d = secCnt_q[7:0];
        ADDR_STAMP_TICKS: rdData_d = ticks_q[7:0];
        ADDR_RX_COUNT:    rdData_d = rxCnt_q;
        ADDR_ID:          rdData_d = BLOCK_ID; // Arbitrary identity value.
        default:          rdData_d = 8'h00;
      endcase
    end
  end

  // Transmit path: a write to the data register queues one byte.
  always_comb begin
    txSt_d   = txSt_q;
    txCnt_d  = txCnt_q;
    txBit_d  = txBit_q;
    txSh_d   = txSh_q;
    txPend_d = txPend_q || (regWr && regAddr == ADDR_TX_DATA);
    txLine   = 1'b1;
    case (txSt_q)
      GTSC_TX_IDLE: begin
        if (txPend_q) begin
          txSt_d   = GTSC_TX_START;
          txSh_d   = txBuf_q;
          txCnt_d  = 16'(BAUD_DIV - 1);
          txPend_d = regWr && regAddr == ADDR_TX_DATA;
        end
      end
      GTSC_TX_START: begin
        txLine = 1'b0;
        if (txCnt_q == 16'h0) begin
          txSt_d  = GTSC_TX_DATA;
          txCnt_d = 16'(BAUD_DIV - 1);
          txBit_d = 3'h0;
        end else txCnt_d = txCnt_q - 16'h1;
      end
      GTSC_TX_DATA: begin
        txLine = txSh_q[txBit_q];
        if (txCnt_q == 16'h0) begin
          txCnt_d = 16'(BAUD_DIV - 1);
          txBit_d = txBit_q + 3'h1;
          if (txBit_q == 3'h7) txSt_d = GTSC_TX_STOP;
        end else txCnt_d = txCnt_q - 16'h1;
      end
      GTSC_TX_STOP: begin
        if (txCnt_q == 16'h0) txSt_d = GTSC_TX_IDLE;
        else txCnt_d = txCnt_q - 16'h1;
      end
      default: txSt_d = GTSC_TX_IDLE;
    endcase
  end

  // State registers, frozen while the clock enable is low.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_q      <= CFG_RESET;
      lampProg_q <= 1'b0;
      trigErr_q  <= 1'b0;
      red_q      <= 1'b0;
      yel_q      <= 1'b0;
      secCnt_q   <= 32'h0;
      ticks_q    <= 32'h0;
      hiWidth_q  <= 8'h00;
      rxCnt_q    <= 8'h00;
      rdData_q   <= 8'h00;
      txBuf_q    <= 8'h00;
      txSt_q     <= GTSC_TX_IDLE;
      txCnt_q    <= 16'h0;
      txBit_q    <= 3'h0;
      txSh_q     <= 8'h00;
      txPend_q   <= 1'b0;
      sv_q       <= 1'b0;
      st_q       <= TAG_SAMPLE;
      sd_q       <= 32'h0;
      sdin_q     <= '0;
      conv_q     <= 1'b0;
      serialTxPin <= 1'b1;
    end else if (clkEn) begin
      cfg_q      <= cfg_d;
      lampProg_q <= lampProg_d;
      trigErr_q  <= trigErr_d;
      red_q      <= red_d;
      yel_q      <= yel_d;
      secCnt_q   <= secCnt_d;
      ticks_q    <= ticks_d;
      hiWidth_q  <= hiWidth_d;
      rxCnt_q    <= rxCnt_d;
      rdData_q   <= rdData_d;
      txBuf_q    <= txBuf_d;
      txSt_q     <= txSt_d;
      txCnt_q    <= txCnt_d;
      txBit_q    <= txBit_d;
      txSh_q     <= txSh_d;
      txPend_q   <= txPend_d;
      sv_q       <= sv_d;
      st_q       <= st_d;
      sd_q       <= sd_d;
      sdin_q     <= sdin_d;
      conv_q     <= conv_d;
      serialTxPin <= txLine ^ cfg_q[CFG_TX_IDLE];
    end
  end

  assign regRdData    = rdData_q;
  assign redLamp      = red_q;
  assign yellowLamp   = yel_q;
  assign convReadyPin = conv_q;
  assign streamValid  = sv_q;
  assign streamTag    = st_q;
  assign streamData   = sd_q;
  assign streamDin    = sdin_q;

  // Checks.
  property p_red(c);
    @(posedge clk) disable iff (!rst_n) (clkEn && secTick && !cfg_q[CFG_LAMP_SRC]) |=> (red_q != $past(red_q));
  endproperty
  redLampToggle_a: assert property (p_red(1'b1)) else $error("Red lamp missed a tick.");
  yelLampToggle_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && bufferHandedOff) |=> (yel_q != $past(yel_q))) else $error("Yellow lamp missed a buffer.");
  convGate_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && !cfg_q[CFG_CONV_EN]) |=> !convReadyPin) else $error("Ready output while disabled.");
  cfgReserved_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_q[1] == 1'b0 && cfg_q[3] == 1'b0)) else $error("Reserved bit stored.");
  sequence s_sample; clkEn && sampleValid; endsequence
  sampleStore_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_sample |=> (streamValid && streamTag == TAG_SAMPLE && streamDin == $past(dinB_q))) else $error("Sample lost.");
  stampReset_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && secTick) |=> (ticks_q == 32'h0)) else $error("Stamp counter not restarted.");
  lampProg_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && cfg_q[CFG_LAMP_SRC] && $stable(cfg_q)) |=> (redLamp == $past(lampProg_q))) else $error("Lamp not programmed.");
  txIdle_a: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && txSt_q == GTSC_TX_IDLE) |=> (serialTxPin == ($past(cfg_q[CFG_TX_IDLE]) ^ 1'b1))) else $error("Tx not idle.");
endmodule : gtsc_timing_signal_config

// ---- core/gtsc_pkg.sv ----
// Purpose: Shared constants for the timing and satellite-signal configuration block.
// Assumes: 100 MHz system clock, register port with one-cycle read latency.
// Notes:   Offsets are word addresses on the plain register port.
package gtsc_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned BAUD            = 4800;
  localparam int unsigned BAUD_DIV        = CLK_HZ / BAUD;
  localparam int unsigned PULSE_MIN_NS    = 100;
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned PULSE_MIN_CYC   = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned AW              = 4;
  // Register word addresses.
  localparam logic [3:0] ADDR_CFG         = 4'h0;
  localparam logic [3:0] ADDR_LAMP        = 4'h1;
  localparam logic [3:0] ADDR_STATUS      = 4'h2;
  localparam logic [3:0] ADDR_SEC_CNT     = 4'h3;
  localparam logic [3:0] ADDR_STAMP_TICKS = 4'h4;
  localparam logic [3:0] ADDR_TX_DATA     = 4'h5;
  localparam logic [3:0] ADDR_RX_COUNT    = 4'h6;
  localparam logic [3:0] ADDR_ID          = 4'h7;
  // Configuration byte field positions.
  localparam int unsigned CFG_TRIG_IDLE   = 0;
  localparam int unsigned CFG_CONV_EN     = 2;
  localparam int unsigned CFG_SEC_IDLE    = 4;
  localparam int unsigned CFG_LAMP_SRC    = 5;
  localparam int unsigned CFG_RX_IDLE     = 6;
  localparam int unsigned CFG_TX_IDLE     = 7;
  localparam logic [7:0] CFG_RESET        = 8'h00;
  localparam logic [7:0] CFG_USED_MASK    = 8'hf5;
  // Stream record tags.
  localparam logic [1:0] TAG_SAMPLE       = 2'h0;
  localparam logic [1:0] TAG_SECOND       = 2'h1;
  localparam logic [1:0] TAG_SENTENCE     = 2'h2;
  typedef enum logic [1:0] {
    GTSC_TX_IDLE  = 2'b00,
    GTSC_TX_START = 2'b01,
    GTSC_TX_DATA  = 2'b10,
    GTSC_TX_STOP  = 2'b11
  } gtsc_txst_e;
endpackage : gtsc_pkg

// ---- core/gtsc_uart_if.sv ----
// Purpose: Carries received serial bytes from the receiver module to the top.
// Assumes: Single clock domain.
// Notes:   The strobe is a one-cycle pulse with the byte beside it.
`timescale 1ns/1ps
interface gtsc_uart_if;
  logic       byteValid;
  logic [7:0] byteData;
  logic       frameErr;
  modport rx  (output byteValid, output byteData, output frameErr);
  modport top (input byteValid, input byteData, input frameErr);
endinterface : gtsc_uart_if

// ---- core/gtsc_uart_rx.sv ----
// Purpose: 8N1 serial receiver for satellite sentences at the sentence baud rate.
// Assumes: Input already synchronised and corrected to idle-high sense.
// Notes:   Samples at the bit centre; a low stop bit flags a framing error.
`timescale 1ns/1ps
module gtsc_uart_rx
  import gtsc_pkg::*;
#(
  parameter int unsigned DIV = BAUD_DIV
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic clkEn,
  input  wire logic rxLine,
  gtsc_uart_if.rx   up
);
  logic        busy_q,  busy_d;
  logic [15:0] cnt_q,   cnt_d;
  logic [3:0]  bit_q,   bit_d;
  logic [7:0]  sh_q,    sh_d;
  logic        vld_q,   vld_d;
  logic        err_q,   err_d;

  // Next state: wait for a start bit, then sample ten bit centres.
  always_comb begin
    busy_d = busy_q;
    cnt_d  = cnt_q;
    bit_d  = bit_q;
    sh_d   = sh_q;
    vld_d  = 1'b0;
    err_d  = 1'b0;
    if (!busy_q) begin
      if (!rxLine) begin
        busy_d = 1'b1;
        cnt_d  = 16'(DIV / 2);
        bit_d  = 4'h0;
      end
    end else if (cnt_q != 16'h0000) begin
      cnt_d = cnt_q - 16'h0001;
    end else begin
      cnt_d = 16'(DIV - 1);
      if (bit_q == 4'h0) begin
        if (rxLine) busy_d = 1'b0; // Start glitch is discarded.
        bit_d = 4'h1;
      end else if (bit_q < 4'h9) begin
        sh_d  = {rxLine, sh_q[7:1]};
        bit_d = bit_q + 4'h1;
      end else begin
        busy_d = 1'b0;
        vld_d  = rxLine;
        err_d  = !rxLine;
      end
    end
  end

  // Registers only.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      cnt_q  <= 16'h0000;
      bit_q  <= 4'h0;
      sh_q   <= 8'h00;
      vld_q  <= 1'b0;
      err_q  <= 1'b0;
    end else if (clkEn) begin
      busy_q <= busy_d;
      cnt_q  <= cnt_d;
      bit_q  <= bit_d;
      sh_q   <= sh_d;
      vld_q  <= vld_d;
      err_q  <= err_d;
    end
  end

  assign up.byteValid = vld_q;
  assign up.byteData  = sh_q;
  assign up.frameErr  = err_q;
endmodule : gtsc_uart_rx

// ---- test/gtsc_receiver_model.sv ----
// Purpose: Behavioural satellite timing receiver that drives the second pulse and the sentence line.
// Assumes: Pulse widths and gaps are counted in bench clock cycles.
// Notes:   No sentences are sent, because one byte at the link rate outlasts the whole run.
`timescale 1ns/1ps
module gtsc_receiver_model (
  input  wire logic clk,
  input  wire logic pulseIdleHigh,
  input  wire logic rxIdleLow,
  output logic      secondPulsePin,
  output logic      serialRxPin
);
  logic pulseActive = 1'b0;

  // The leading edge marks the second; the pin rests at the chosen idle level.
  assign secondPulsePin = pulseActive ^ pulseIdleHigh;
  // The sentence line rests at its idle level for the whole run; no sentence bursts are sent.
  assign serialRxPin = ~rxIdleLow;

  // One second pulse of the given width, then a quiet gap so that edges never crowd each other.
  task automatic tick(input int width);
    pulseActive <= 1'b1;
    repeat (width) @(posedge clk);
    pulseActive <= 1'b0;
    repeat (40) @(posedge clk);
  endtask : tick
endmodule : gtsc_receiver_model

// ---- test/gtsc_timing_signal_config_test.sv ----
// Purpose: Self-checking bench for the timing-pin configuration block.
// Assumes: Received sentence bytes are not exercised; one byte at the link rate outlasts the run.
// Notes:   Tasks start just after a rising edge and sample 1 ns after an edge.
`timescale 1ns/1ps
module gtsc_timing_signal_config_test;
  import gtsc_pkg::*;
  logic        clk, rst_n, clkEn, regWr, regRd, secondPulsePin, triggerPin, serialRxPin;
  logic        serialTxPin, convDone, convReadyPin, sampleValid, bufferHandedOff, redLamp;
  logic        yellowLamp, triggerEvent, streamValid, pulseIdleHigh, rxIdleLow;
  logic [3:0]  regAddr, digitalInPin, streamDin;
  logic [7:0]  regWrData, regRdData;
  logic [23:0] sampleData;
  logic [1:0]  streamTag;
  logic [31:0] streamData, lastSecData;
  int          failures = 0, checks = 0, cycles = 0, secRecs = 0, sampRecs = 0, trigCnt = 0;

  gtsc_timing_signal_config dut_u (
    .clk, .rst_n, .clkEn, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .secondPulsePin,
    .triggerPin, .serialRxPin, .serialTxPin, .convDone, .convReadyPin, .digitalInPin, .sampleValid,
    .sampleData, .bufferHandedOff, .redLamp, .yellowLamp, .triggerEvent, .streamValid, .streamTag,
    .streamData, .streamDin
  );

  gtsc_receiver_model model_u (.clk, .pulseIdleHigh, .rxIdleLow, .secondPulsePin, .serialRxPin);

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Counts trigger pulses and stream records, and cuts a hang short.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (triggerEvent === 1'b1) trigCnt <= trigCnt + 1;
    if (streamValid === 1'b1 && streamTag === TAG_SAMPLE) sampRecs <= sampRecs + 1;
    if (streamValid === 1'b1 && streamTag === TAG_SECOND) begin
      secRecs <= secRecs + 1;
      lastSecData <= streamData;
    end
    if (cycles == 40000) begin
      failures = failures + 1;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] expd, input string what);
    checks = checks + 1;
    if (seen !== expd) begin
      failures = failures + 1;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, expd);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  // The extra edge after each strobe keeps a following strobe out of the same time step.
  task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask : regWrite

  task automatic regRead(input logic [3:0] a, output logic [7:0] d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdData;
    @(posedge clk);
  endtask : regRead

  // The model's idle levels follow the configuration, as a matching receiver would.
  task automatic setCfg(input logic [7:0] d);
    regWrite(ADDR_CFG, d);
    pulseIdleHigh <= d[CFG_SEC_IDLE];
    rxIdleLow <= d[CFG_RX_IDLE];
    repeat (8) @(posedge clk);
  endtask : setCfg

  task automatic t_reset();
    logic [7:0] d;
    #1 check(serialTxPin, 1'b1, "tx idle");
    check(redLamp, 1'b0, "red lamp");
    check(convReadyPin, 1'b0, "conv ready");
    @(posedge clk);
    regRead(ADDR_CFG, d);
    check(d, CFG_RESET, "cfg reset");
    regWrite(ADDR_CFG, 8'h2e);
    regRead(ADDR_CFG, d);
    check(d, 8'h2e & CFG_USED_MASK, "reserved bits");
    regRead(4'hc, d);
    check(d, 8'h00, "unmapped read");
    setCfg(8'h00);
  endtask : t_reset

  task automatic t_second();
    logic [7:0] d;
    logic       base;
    int         s;
    #1 base = redLamp;
    s = secRecs;
    @(posedge clk);
    model_u.tick(20);
    #1 check(redLamp ^ base, 1'b1, "lamp toggle");
    check(secRecs, s + 1, "one tick per pulse");
    check(lastSecData[7:0], 8'h01, "second count in stream");
    @(posedge clk);
    // Stamp counter restarts three edges after the pulse is launched and is read 61 edges after it.
    regRead(ADDR_STAMP_TICKS, d);
    check(d, 8'h3a, "stamp ticks since second");
    model_u.tick(5);
    regRead(ADDR_STATUS, d);
    check(d[0], 1'b1, "short pulse flag");
    regWrite(ADDR_STATUS, 8'h01);
    regRead(ADDR_STATUS, d);
    check(d[0], 1'b0, "flag cleared");
    regRead(ADDR_SEC_CNT, d);
    check(d, 8'h02, "second count");
    setCfg(8'h10);
    #1 base = redLamp;
    s = secRecs;
    @(posedge clk);
    model_u.tick(20);
    #1 check(redLamp ^ base, 1'b1, "falling edge tick");
    check(secRecs, s + 1, "one tick idle high");
    @(posedge clk);
    setCfg(8'h20);
    regWrite(ADDR_LAMP, 8'h01);
    model_u.tick(20);
    #1 check(redLamp, 1'b1, "programmed red held");
    @(posedge clk);
    regWrite(ADDR_LAMP, 8'h00);
    #1 check(redLamp, 1'b0, "programmed red off");
    @(posedge clk);
    setCfg(8'h00);
  endtask : t_second

  task automatic t_trigger();
    int c;
    #1 c = trigCnt;
    @(posedge clk);
    triggerPin <= 1'b1;
    repeat (8) @(posedge clk);
    triggerPin <= 1'b0;
    repeat (8) @(posedge clk);
    #1 check(trigCnt, c + 1, "rising edge only");
    @(posedge clk);
    triggerPin <= 1'b1;
    setCfg(8'h01);
    #1 c = trigCnt;
    @(posedge clk);
    triggerPin <= 1'b0;
    repeat (8) @(posedge clk);
    triggerPin <= 1'b1;
    repeat (8) @(posedge clk);
    #1 check(trigCnt, c + 1, "falling edge when idle high");
    @(posedge clk);
  endtask : t_trigger

  task automatic t_conv_lamp_sample();
    logic base;
    int   s;
    convDone <= 1'b1;
    @(posedge clk);
    convDone <= 1'b0;
    #1 check(convReadyPin, 1'b0, "conv ready disabled");
    @(posedge clk);
    setCfg(8'h04);
    convDone <= 1'b1;
    @(posedge clk);
    convDone <= 1'b0;
    #1 check(convReadyPin, 1'b1, "conv ready strobe");
    @(posedge clk);
    #1 check(convReadyPin, 1'b0, "conv ready ends");
    base = yellowLamp;
    @(posedge clk);
    bufferHandedOff <= 1'b1;
    @(posedge clk);
    bufferHandedOff <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check(yellowLamp ^ base, 1'b1, "yellow toggle");
    // A handover seen while the clock enable is low must leave the lamp alone.
    @(posedge clk);
    clkEn <= 1'b0;
    bufferHandedOff <= 1'b1;
    @(posedge clk);
    bufferHandedOff <= 1'b0;
    clkEn <= 1'b1;
    repeat (2) @(posedge clk);
    #1 check(yellowLamp ^ base, 1'b1, "frozen while clock enable low");
    s = sampRecs;
    @(posedge clk);
    digitalInPin <= 4'ha;
    repeat (4) @(posedge clk);
    sampleValid <= 1'b1;
    sampleData <= 24'habcdef;
    @(posedge clk);
    sampleData <= 24'h123456;
    @(posedge clk);
    sampleValid <= 1'b0;
    #1 check(streamTag, TAG_SAMPLE, "sample tag");
    check(streamData, 32'h00123456, "sample data");
    check(streamDin, 4'ha, "inputs with sample");
    @(posedge clk);
    #1 check(sampRecs, s + 2, "back to back samples");
    @(posedge clk);
  endtask : t_conv_lamp_sample

  task automatic t_tx();
    logic [7:0] d;
    setCfg(8'h80);
    #1 check(serialTxPin, 1'b0, "tx idle low");
    @(posedge clk);
    setCfg(8'h00);
    #1 check(serialTxPin, 1'b1, "tx idle high");
    @(posedge clk);
    regWrite(ADDR_TX_DATA, 8'h01);
    regRead(ADDR_STATUS, d);
    check(d[2], 1'b1, "tx busy");
    repeat (BAUD_DIV - 40) @(posedge clk);
    #1 check(serialTxPin, 1'b0, "start bit length");
    @(posedge clk);
    repeat (60) @(posedge clk);
    #1 check(serialTxPin, 1'b1, "first data bit");
    @(posedge clk);
  endtask : t_tx

  // Main sequence: reset for two cycles, then each scenario in turn.
  initial begin
    rst_n = 1'b0;
    clkEn = 1'b1;
    regAddr = 4'h0;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    triggerPin = 1'b0;
    convDone = 1'b0;
    digitalInPin = 4'h0;
    sampleValid = 1'b0;
    sampleData = 24'h000000;
    bufferHandedOff = 1'b0;
    pulseIdleHigh = 1'b0;
    rxIdleLow = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_second();
    t_trigger();
    t_conv_lamp_sample();
    t_tx();
    report_and_stop();
  end
endmodule : gtsc_timing_signal_config_test
